// ===== rtl/ubf_break_flags.sv
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - channel C DMA-cycle match sets flag bit 14
// - channel D CPU-cycle match sets flag bit 7
// - channel D DMA-cycle match sets flag bit 6
// - hardware never clears match flags; software clears them by writing
// - channel C count enable: break only when match count equals count register
// - channel D count enable: break only when match count equals count register
// - bit 11 adds data compare to channel C condition, reset zero
// - bit 3 adds data compare to channel D condition, reset zero
// - bit 10 selects fetch break before (0) or after (1), channel C
// - bit 2 selects fetch break before (0) or after (1), channel D
// - reserved control and trace-flag bits read zero
// - four read-only 16-bit branch flag entries shift per traced branch
// - source-valid bit 15 set on target fetch, cleared by source read
// - dest-valid bit 7 set on target fetch, cleared by dest read
// - bits 14:12 hold 3-bit instruction buffer pointer
// - reset clears valid flags, leaves buffer pointer alone
// - satisfied condition requests break interrupt and sets channel flag by cycle type at firing (retire cycle if after-fetch); channel C CPU matches set none
// - address queues shift along but are never reset
module ubf_break_flags (
	input wire logic clock,
	input wire logic rst,
	input wire logic clkEn,
	input wire ubf_pkg::ubf_match_t chanC,
	input wire ubf_pkg::ubf_match_t chanD,
	input wire logic instrRetired,
	input wire ubf_pkg::ubf_branch_t branch,
	input wire logic targetFetched,
	input wire logic [31:0] branchSrcAddr,
	input wire logic [31:0] branchDstAddr,
	output logic breakReq,
	output logic traceEnable,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import ubf_pkg::*;

	logic [15:0] ctrl_r, ctrl_nxt;
	logic [15:0] cntC_r, cntC_nxt, cntD_r, cntD_nxt;
	logic [15:0] hitC_r, hitC_nxt, hitD_r, hitD_nxt;
	logic pendC_r, pendC_nxt, pendD_r, pendD_nxt;
	logic [QDEPTH-1:0] svf_r, svf_nxt, dvf_r, dvf_nxt;
	logic [2:0] ptr_r [QDEPTH];
	logic [31:0] srcQ_r [QDEPTH];
	logic [31:0] dstQ_r [QDEPTH];
	logic breakReq_r, breakReq_nxt;
	logic traceOn_r, traceOn_nxt;
	logic haveAw_r, haveAw_nxt, haveW_r, haveW_nxt;
	logic [7:0] awAddr_r, awAddr_nxt;
	logic [31:0] wData_r, wData_nxt;
	logic [3:0] wStrb_r, wStrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;

	logic condC, condD, fireC, fireD, doWrite, doRead, shiftQ;
	logic [31:0] wMask, newData;

	// data compare only joins the condition when enabled
	always_comb
	begin
		condC = chanC.addrMatch & (chanC.dataMatch | ~ctrl_r[DATA_EN_C_BIT]);
		condD = chanD.addrMatch & (chanD.dataMatch | ~ctrl_r[DATA_EN_D_BIT]);
		// after-execution fetch breaks wait for the retire strobe
		// fetch cycle is long gone when the retire strobe arrives, so the latch fires alone
		fireC = (pendC_r & instrRetired)
			| (condC & ~(chanC.fetchCycle & ctrl_r[AFTER_C_BIT]));
		fireD = (pendD_r & instrRetired)
			| (condD & ~(chanD.fetchCycle & ctrl_r[AFTER_D_BIT]));
		pendC_nxt = (condC & chanC.fetchCycle & ctrl_r[AFTER_C_BIT])
			| (pendC_r & ~instrRetired);
		pendD_nxt = (condD & chanD.fetchCycle & ctrl_r[AFTER_D_BIT])
			| (pendD_r & ~instrRetired);
	end

	assign doWrite = haveAw_r & haveW_r & ~bvalid_r;
	assign doRead = s_axi_arvalid & ~rvalid_r;
	assign shiftQ = branch.taken & traceOn_r;
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			wMask[i*8 +: 8] = {8{wStrb_r[i]}};
		newData = wData_r & wMask;
	end

	// control, counters, break request
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		cntC_nxt = cntC_r;
		cntD_nxt = cntD_r;
		hitC_nxt = hitC_r;
		hitD_nxt = hitD_r;
		breakReq_nxt = 1'b0;
		traceOn_nxt = traceOn_r;
		if (doWrite && awAddr_r == CTRL_OFFS)
		begin
			// flags: writing 0 clears, writing 1 keeps; reserved bits stay zero
			ctrl_nxt = (ctrl_r & 16'h40c0 & ~(wMask[15:0] & ~wData_r[15:0]))
				| (((ctrl_r & ~wMask[15:0]) | newData[15:0]) & 16'h2c2c);
			traceOn_nxt = wStrb_r[2] ? wData_r[16] : traceOn_r;
		end
		if (doWrite && awAddr_r == CNTC_OFFS)
		begin
			cntC_nxt = newData[15:0] | (cntC_r & ~wMask[15:0]);
			hitC_nxt = 16'h0000;
		end
		if (doWrite && awAddr_r == CNTD_OFFS)
		begin
			cntD_nxt = newData[15:0] | (cntD_r & ~wMask[15:0]);
			hitD_nxt = 16'h0000;
		end
		if (fireC)
		begin
			if (ctrl_r[CNT_EN_C_BIT])
			begin
				hitC_nxt = hitC_r + 16'h0001;
				if (hitC_r + 16'h0001 == cntC_r)
				begin
					breakReq_nxt = 1'b1;
					hitC_nxt = 16'h0000;
					ctrl_nxt[CMF_C_DMA_BIT] = ctrl_nxt[CMF_C_DMA_BIT] | chanC.dmaCycle;
				end
			end
			else
			begin
				breakReq_nxt = 1'b1;
				ctrl_nxt[CMF_C_DMA_BIT] = ctrl_nxt[CMF_C_DMA_BIT] | chanC.dmaCycle;
			end
		end
		if (fireD)
		begin
			if (ctrl_r[CNT_EN_D_BIT])
			begin
				hitD_nxt = hitD_r + 16'h0001;
				if (hitD_r + 16'h0001 == cntD_r)
				begin
					breakReq_nxt = 1'b1;
					hitD_nxt = 16'h0000;
					ctrl_nxt[CMF_D_CPU_BIT] = ctrl_nxt[CMF_D_CPU_BIT] | chanD.cpuCycle;
					ctrl_nxt[CMF_D_DMA_BIT] = ctrl_nxt[CMF_D_DMA_BIT] | chanD.dmaCycle;
				end
			end
			else
			begin
				breakReq_nxt = 1'b1;
				ctrl_nxt[CMF_D_CPU_BIT] = ctrl_nxt[CMF_D_CPU_BIT] | chanD.cpuCycle;
				ctrl_nxt[CMF_D_DMA_BIT] = ctrl_nxt[CMF_D_DMA_BIT] | chanD.dmaCycle;
			end
		end
	end

	// valid flags: head entry is what software reads; a set beats a read clear
	always_comb
	begin
		svf_nxt = svf_r;
		dvf_nxt = dvf_r;
		if (doRead && s_axi_araddr[7:0] == SRCR_OFFS)
			svf_nxt[0] = 1'b0;
		if (doRead && s_axi_araddr[7:0] == DSTR_OFFS)
			dvf_nxt[0] = 1'b0;
		if (shiftQ)
		begin
			svf_nxt = {1'b0, svf_nxt[QDEPTH-1:1]};
			dvf_nxt = {1'b0, dvf_nxt[QDEPTH-1:1]};
		end
		if (targetFetched & traceOn_r)
		begin
			svf_nxt[QDEPTH-1] = 1'b1;
			dvf_nxt[QDEPTH-1] = 1'b1;
		end
	end

	// bus slave next state
	always_comb
	begin
		haveAw_nxt = haveAw_r;
		haveW_nxt = haveW_r;
		awAddr_nxt = awAddr_r;
		wData_nxt = wData_r;
		wStrb_nxt = wStrb_r;
		bvalid_nxt = bvalid_r & ~s_axi_bready;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r & ~s_axi_rready;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_awvalid & s_axi_awready)
		begin
			haveAw_nxt = 1'b1;
			awAddr_nxt = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid & s_axi_wready)
		begin
			haveW_nxt = 1'b1;
			wData_nxt = s_axi_wdata;
			wStrb_nxt = s_axi_wstrb;
		end
		if (doWrite)
		begin
			haveAw_nxt = 1'b0;
			haveW_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = (awAddr_r == CTRL_OFFS || awAddr_r == CNTC_OFFS
				|| awAddr_r == CNTD_OFFS) ? RESP_OKAY : RESP_SLVERR;
		end
		if (doRead)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			case (s_axi_araddr[7:0])
				CTRL_OFFS: rdata_nxt = {15'h0000, traceOn_r, ctrl_r & CTRL_RW_MASK};
				FLAG_OFFS: rdata_nxt = {16'h0000, svf_r[0], ptr_r[0], 4'h0, dvf_r[0],
					7'h00};
				CNTC_OFFS: rdata_nxt = {16'h0000, cntC_r};
				CNTD_OFFS: rdata_nxt = {16'h0000, cntD_r};
				SRCR_OFFS: rdata_nxt = srcQ_r[0];
				DSTR_OFFS: rdata_nxt = dstQ_r[0];
				default:
				begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end
	end

	assign s_axi_awready = ~haveAw_r;
	assign s_axi_wready = ~haveW_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign breakReq = breakReq_r;
	assign traceEnable = traceOn_r;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ctrl_r <= CTRL_RESET;
			cntC_r <= CNT_RESET;
			cntD_r <= CNT_RESET;
			hitC_r <= CNT_RESET;
			hitD_r <= CNT_RESET;
			pendC_r <= 1'b0;
			pendD_r <= 1'b0;
			svf_r <= '0;
			dvf_r <= '0;
			breakReq_r <= 1'b0;
			traceOn_r <= 1'b0;
			haveAw_r <= 1'b0;
			haveW_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
		end
		else if (clkEn)
		begin
			ctrl_r <= ctrl_nxt;
			cntC_r <= cntC_nxt;
			cntD_r <= cntD_nxt;
			hitC_r <= hitC_nxt;
			hitD_r <= hitD_nxt;
			pendC_r <= pendC_nxt;
			pendD_r <= pendD_nxt;
			svf_r <= svf_nxt;
			dvf_r <= dvf_nxt;
			breakReq_r <= breakReq_nxt;
			traceOn_r <= traceOn_nxt;
			haveAw_r <= haveAw_nxt;
			haveW_r <= haveW_nxt;
			awAddr_r <= awAddr_nxt;
			wData_r <= wData_nxt;
			wStrb_r <= wStrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// queues without reset; tail fills at the branch, head is read
	generate
		for (genvar e = 0; e < QDEPTH; e++)
		begin : gQueue
			always_ff @(posedge clock)
			begin
				if (clkEn & shiftQ)
				begin
					if (e == QDEPTH - 1)
					begin
						ptr_r[e] <= branch.bufPtr;
						srcQ_r[e] <= branchSrcAddr;
						dstQ_r[e] <= branchDstAddr;
					end
					else
					begin
						ptr_r[e] <= ptr_r[e+1];
						srcQ_r[e] <= srcQ_r[e+1];
						dstQ_r[e] <= dstQ_r[e+1];
					end
				end
			end
		end
	endgenerate
endmodule

// ===== rtl/ubf_pkg.sv
package ubf_pkg;
	localparam logic [7:0] CTRL_OFFS = 8'h00;
	localparam logic [7:0] FLAG_OFFS = 8'h04;
	localparam logic [7:0] CNTC_OFFS = 8'h08;
	localparam logic [7:0] CNTD_OFFS = 8'h0c;
	localparam logic [7:0] SRCR_OFFS = 8'h10;
	localparam logic [7:0] DSTR_OFFS = 8'h14;
	localparam int CMF_C_DMA_BIT = 14;
	localparam int CNT_EN_C_BIT = 13;
	localparam int DATA_EN_C_BIT = 11;
	localparam int AFTER_C_BIT = 10;
	localparam int CMF_D_CPU_BIT = 7;
	localparam int CMF_D_DMA_BIT = 6;
	localparam int CNT_EN_D_BIT = 5;
	localparam int DATA_EN_D_BIT = 3;
	localparam int AFTER_D_BIT = 2;
	localparam logic [15:0] CTRL_RW_MASK = 16'h6cec;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam int SVF_BIT = 15;
	localparam int DVF_BIT = 7;
	localparam int PTR_LSB = 12;
	localparam int QDEPTH = 4;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef struct packed {
		logic cpuCycle;
		logic dmaCycle;
		logic addrMatch;
		logic dataMatch;
		logic fetchCycle;
	} ubf_match_t;
	typedef struct packed {
		logic taken;
		logic [2:0] bufPtr;
	} ubf_branch_t;
endpackage

// ===== sim/ubf_monitor.sv
`timescale 1ns/1ps
module ubf_monitor
	import ubf_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire ubf_match_t chanC,
	input wire ubf_match_t chanD,
	input wire logic instrRetired,
	input wire logic breakReq,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid
);
	logic [7:0] rdAddr_r;
	logic [7:0] rdAddr_nxt;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	always_comb
	begin
		rdAddr_nxt = rdAddr_r;
		if (s_axi_arvalid && s_axi_arready)
			rdAddr_nxt = s_axi_araddr[7:0];
	end
	always_ff @(posedge clock)
		rdAddr_r <= rdAddr_nxt;
	reset_idle_a: assert property ($fell(rst) |-> !breakReq && s_axi_arready)
		else $error("not idle after reset");
	break_cause_a: assert property (breakReq |-> $past(chanC.cpuCycle || chanC.dmaCycle ||
		chanD.cpuCycle || chanD.dmaCycle || instrRetired))
		else $error("break without a bus cycle");
	write_answer_a: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
		else $error("no write response");
	read_answer_a: assert property (rdTaken |=> s_axi_rvalid)
		else $error("no read response");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken during read data");
	flag_reserved_a: assert property (s_axi_rvalid && rdAddr_r == FLAG_OFFS |->
		s_axi_rdata[11:8] == 4'h0 && s_axi_rdata[6:0] == 7'h00)
		else $error("reserved trace bits set");
	ctrl_reserved_a: assert property (s_axi_rvalid && rdAddr_r == CTRL_OFFS |->
		(s_axi_rdata & 32'h00001313) == 32'h0)
		else $error("reserved control bits set");
	unmapped_read_a: assert property (s_axi_rvalid && rdAddr_r == 8'h20 |->
		s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read answered");
endmodule
bind ubf_break_flags ubf_monitor mon (.clock(clock), .rst(rst), .chanC(chanC), .chanD(chanD),
	.instrRetired(instrRetired), .breakReq(breakReq), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid));

// ===== sim/ubf_bus_model.sv
`timescale 1ns/1ps
module ubf_bus_model
	import ubf_pkg::*;
(
	input wire logic clock,
	output ubf_match_t chanC,
	output ubf_match_t chanD,
	output logic instrRetired,
	output ubf_branch_t branch,
	output logic targetFetched,
	output logic [31:0] branchSrcAddr,
	output logic [31:0] branchDstAddr
);
	initial
	begin
		chanC = '0;
		chanD = '0;
		instrRetired = 1'b0;
		branch = '0;
		targetFetched = 1'b0;
		branchSrcAddr = '0;
		branchDstAddr = '0;
	end
	task automatic busCycle(input logic toD, input ubf_match_t m);
		@(posedge clock);
		if (toD)
			chanD <= m;
		else
			chanC <= m;
		@(posedge clock);
		chanC <= '0;
		chanD <= '0;
	endtask
	task automatic retire();
		@(posedge clock);
		instrRetired <= 1'b1;
		@(posedge clock);
		instrRetired <= 1'b0;
	endtask
	// addresses turn to their inverse once taken, so stale values cannot pass
	task automatic takeBranch(input logic [2:0] ptr, input logic [31:0] src, input logic [31:0] dst);
		@(posedge clock);
		branch <= {1'b1, ptr};
		branchSrcAddr <= src;
		branchDstAddr <= dst;
		@(posedge clock);
		branch <= {1'b0, ~ptr};
		branchSrcAddr <= ~src;
		branchDstAddr <= ~dst;
		targetFetched <= 1'b1;
		@(posedge clock);
		targetFetched <= 1'b0;
	endtask
endmodule

// ===== sim/ubf_break_flags_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module ubf_break_flags_tb_top;
	import ubf_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd, srcA, dstA;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, breakReq, instrRetired, targetFetched, trEn;
	logic [1:0] bresp, rresp, rr, rb;
	ubf_match_t chanC, chanD;
	ubf_branch_t branch;
	int err_total = 0;
	int check_count = 0;
	always #50 clock = ~clock;
	ubf_bus_model bus (.clock(clock), .chanC(chanC), .chanD(chanD), .instrRetired(instrRetired),
		.branch(branch), .targetFetched(targetFetched), .branchSrcAddr(srcA), .branchDstAddr(dstA));
	ubf_break_flags dut (.clock(clock), .rst(rst), .clkEn(1'b1), .chanC(chanC), .chanD(chanD),
		.instrRetired(instrRetired), .branch(branch), .targetFetched(targetFetched),
		.branchSrcAddr(srcA), .branchDstAddr(dstA), .breakReq(breakReq), .traceEnable(trEn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic stuck();
		err_total++;
		$display("[ERR] %0t bus timeout", $time);
		conclude();
	endtask
	task automatic doReset();
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
	endtask
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge clock);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				rb = bresp;
				break;
			end
		end
		bready <= 1'b0;
		if (i == 50)
			stuck();
	endtask
	task automatic axiRd(input logic [7:0] a);
		int i;
		@(posedge clock);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge clock);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		rd = rdata;
		rr = rresp;
		rready <= 1'b0;
		if (i == 50)
			stuck();
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
		axiRd(a);
		`CHK(rd[15:0], e)
	endtask
	// counts break pulses in the few cycles after a bus cycle
	task automatic watch(input int n);
		int hits;
		hits = 0;
		repeat (4)
		begin
			#1;
			if (breakReq === 1'b1)
				hits++;
			@(posedge clock);
		end
		`CHK(hits, n)
	endtask
	task automatic sRegs();
		rdChk(CTRL_OFFS, 16'h0000);
		rdChk(FLAG_OFFS, 16'h0000);
		axiWr(CTRL_OFFS, 32'h00006cec);
		`CHK(rb, RESP_OKAY)
		rdChk(CTRL_OFFS, 16'h2c2c);
		axiRd(8'h20);
		`CHK(rr, RESP_SLVERR)
		axiWr(8'h20, 32'h0);
		`CHK(rb, RESP_SLVERR)
		axiWr(CTRL_OFFS, 32'h0);
	endtask
	task automatic sFlags();
		bus.busCycle(1'b0, 5'b01100);
		watch(1);
		bus.busCycle(1'b1, 5'b10100);
		watch(1);
		bus.busCycle(1'b1, 5'b01100);
		watch(1);
		rdChk(CTRL_OFFS, 16'h40c0);
		axiWr(CTRL_OFFS, 32'h000040c0);
		rdChk(CTRL_OFFS, 16'h40c0);
		axiWr(CTRL_OFFS, 32'h0);
		rdChk(CTRL_OFFS, 16'h0000);
	endtask
	task automatic sModes();
		for (int c = 0; c < 2; c++)
		begin
			axiWr(CTRL_OFFS, c ? 32'h8 : 32'h800);
			bus.busCycle(c[0], 5'b01100);
			watch(0);
			bus.busCycle(c[0], 5'b01110);
			watch(1);
			axiWr(c ? CNTD_OFFS : CNTC_OFFS, 32'h2);
			axiWr(CTRL_OFFS, c ? 32'h20 : 32'h2000);
			bus.busCycle(c[0], 5'b01100);
			watch(0);
			bus.busCycle(c[0], 5'b01100);
			watch(1);
			rdChk(CTRL_OFFS, c ? 16'h0060 : 16'h6000);
			axiWr(CTRL_OFFS, c ? 32'h4 : 32'h400);
			bus.busCycle(c[0], 5'b10101);
			watch(0);
			bus.retire();
			watch(1);
			axiWr(CTRL_OFFS, 32'h0);
		end
	endtask
	task automatic sTrace();
		axiWr(CTRL_OFFS, 32'h00010000);
		`CHK(trEn, 1'b1)
		for (int i = 0; i < QDEPTH; i++)
			bus.takeBranch(3'(2 * i + 1), 32'h1000 + i, 32'h2000 + i);
		rdChk(FLAG_OFFS, 16'h9080);
		axiRd(DSTR_OFFS);
		`CHK(rd, 32'h2000)
		rdChk(FLAG_OFFS, 16'h9000);
		doReset();
		`CHK(trEn, 1'b0)
		rdChk(FLAG_OFFS, 16'h1000);
		axiRd(SRCR_OFFS);
		`CHK(rd, 32'h1000)
	endtask
	initial
	begin
		doReset();
		sRegs();
		sFlags();
		sModes();
		sTrace();
		conclude();
	end
endmodule
